/* File: design/fabric_window_pkg.sv */
package fabric_window_pkg;

   // ----------------------------------------
   // Register indices on the configuration port
   // ----------------------------------------
   localparam logic [3:0] IDX_IN_TRANS     = 4'h0;
   localparam logic [3:0] IDX_IN_BASE      = 4'h1;
   localparam logic [3:0] IDX_IN_ATTR      = 4'h2;
   localparam logic [3:0] IDX_OUT_TARGET   = 4'h3;
   localparam logic [3:0] IDX_OUT_ATTR     = 4'h4;
   localparam logic [3:0] IDX_LOCAL_ACCESS_WINDOW_ZERO_BASE    = 4'h5;
   localparam logic [3:0] IDX_LOCAL_ACCESS_WINDOW_ZERO_ATTR    = 4'h6;
   localparam logic [3:0] IDX_PORT_CTRL    = 4'h9;
   localparam logic [3:0] IDX_CORE_CFG     = 4'hA;
   localparam int         NUM_LAW          = 2;

   // ----------------------------------------
   // Field positions (bit 0 of a field table is the word's MSB)
   // ----------------------------------------
   localparam int EN_BIT     = 31;
   localparam int FLOW_LSB   = 26;
   localparam int ORDER_BIT  = 25;
   localparam int PORT_LSB   = 20;
   localparam int RDK_LSB    = 16;
   localparam int WRK_LSB    = 12;
   localparam int SIZE_LSB   = 0;
   localparam int DEST_LSB   = 22;
   localparam int EXT_LSB    = 20;
   localparam int ADDR_LSB   = 0;
   localparam int PAGE_BITS  = 12;

   // ----------------------------------------
   // Writable masks and reset values
   // ----------------------------------------
   localparam logic [31:0] IN_TRANS_WMASK   = 32'h000F_FFFF;
   localparam logic [31:0] IN_BASE_WMASK    = 32'h003F_FFFF;
   localparam logic [31:0] IN_ATTR_WMASK    = 32'h80FF_F03F;
   localparam logic [31:0] OUT_TARGET_WMASK = 32'h3FFF_FFFF;
   localparam logic [31:0] OUT_ATTR_WMASK   = 32'h0E0F_F03F;
   localparam logic [31:0] OUT_ATTR_FIXED   = 32'h8000_0000;
   localparam logic [31:0] LAW_BASE_WMASK   = 32'h000F_FFFF;
   localparam logic [31:0] LAW_ATTR_WMASK   = 32'h80F0_003F;
   localparam logic [31:0] CTRL_WMASK       = 32'h8000_0000;
   localparam logic [31:0] REG_RESET        = 32'h0000_0000;

   // ----------------------------------------
   // Codes and the boot region
   // ----------------------------------------
   localparam logic [3:0]  PORT_FABRIC      = 4'hC;
   localparam logic [3:0]  PORT_MEMORY      = 4'hF;
   localparam logic [3:0]  PORT_NONE        = 4'h0;
   localparam logic [3:0]  KIND_NREAD       = 4'h4;
   localparam logic [3:0]  KIND_NWRITE      = 4'h4;
   localparam logic [3:0]  KIND_RESERVED    = 4'h0;
   localparam logic [5:0]  SIZE_FULL        = 6'h1F;
   localparam logic [31:0] BOOT_BASE        = 32'hFF80_0000;
   localparam logic [31:0] BOOT_MASK        = 32'h007F_FFFF;

   // Size code n covers 2**(n+1) bytes
   function automatic logic [31:0] size_mask(input logic [5:0] code);
      logic [31:0] m;
      m = 32'h0000_0000;
      if (code >= SIZE_FULL)
         m = 32'hFFFF_FFFF;
      else
         m = (32'h0000_0001 << (code + 6'h01)) - 32'h0000_0001;
      return m;
   endfunction

   function automatic logic window_hit(input logic [31:0] addr,
                                       input logic [19:0] page,
                                       input logic [5:0]  code);
      logic [31:0] m;
      m = size_mask(code);
      return ((addr ^ {page, 12'h000}) & ~m) == 32'h0000_0000;
   endfunction

   // Offset below the window size passes through untouched
   function automatic logic [31:0] translate(input logic [31:0] addr,
                                             input logic [19:0] page,
                                             input logic [5:0]  code);
      logic [31:0] m;
      m = size_mask(code);
      return ({page, 12'h000} & ~m) | (addr & m);
   endfunction

endpackage

/* File: design/inbound_translator.sv */
`timescale 1ns/1ps
`default_nettype none
module inbound_translator
(
   // Incoming fabric access
   input  wire logic [31:0] i_addr,
   input  wire logic [1:0]  i_ext,
   input  wire logic        i_write,
   // Window registers
   input  wire logic [31:0] i_base,
   input  wire logic [31:0] i_attr,
   input  wire logic [31:0] i_trans,
   // Result
   output logic             o_hit,
   output logic [31:0]      o_addr,
   output logic             o_to_memory,
   output logic             o_refused
);

   logic [5:0] size_code;

   always_comb
   begin
      size_code   = i_attr[fabric_window_pkg::SIZE_LSB +: 6];
      o_hit       = i_attr[fabric_window_pkg::EN_BIT] &&
                    (i_ext == i_base[fabric_window_pkg::EXT_LSB +: 2]) &&
                    fabric_window_pkg::window_hit(i_addr, i_base[19:0], size_code);
      o_addr      = fabric_window_pkg::translate(i_addr,
                       i_trans[fabric_window_pkg::ADDR_LSB +: 20], size_code);
      o_to_memory = i_attr[fabric_window_pkg::PORT_LSB +: 4] ==
                    fabric_window_pkg::PORT_MEMORY;
      // Reserved write code leaves the window read only
      o_refused   = i_write && (i_attr[fabric_window_pkg::WRK_LSB +: 4] ==
                    fabric_window_pkg::KIND_RESERVED);
   end

endmodule
`default_nettype wire

/* File: design/local_window_router.sv */
`timescale 1ns/1ps
`default_nettype none
module local_window_router
(
   // Request address
   input  wire logic [31:0]                        i_addr,
   // Window registers
   input  wire logic [fabric_window_pkg::NUM_LAW-1:0][31:0] i_base,
   input  wire logic [fabric_window_pkg::NUM_LAW-1:0][31:0] i_attr,
   // Result
   output logic                                    o_hit,
   output logic [3:0]                              o_port
);

   always_comb
   begin
      o_hit  = 1'b0;
      o_port = fabric_window_pkg::PORT_NONE;
      // Walk downward from the last window so window zero is written last
      for (int i = fabric_window_pkg::NUM_LAW - 1; i >= 0; i--)
      begin
         if (i_attr[i][fabric_window_pkg::EN_BIT] &&
             fabric_window_pkg::window_hit(i_addr, i_base[i][19:0],
                i_attr[i][fabric_window_pkg::SIZE_LSB +: 6]))
         begin
            o_hit  = 1'b1;
            o_port = i_attr[i][fabric_window_pkg::PORT_LSB +: 4];
         end
      end
   end

endmodule
`default_nettype wire

/* File: design/serial_fabric_window_translation.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Inbound hits take the translation address field as their upper address bits.
// - Every fabric-bound local access goes through the default outbound window.
// - Default outbound window enable always reads one and ignores writes.
// - Outbound target register gives destination id, extended bits, translated address.
// - Attributes give flow priority and the ordered-transaction flag.
// - Read kind field selects the fabric read; code 0100 gives NREAD.
// - Write kind field selects the fabric write; code 0100 gives NWRITE.
// - Window size comes from the size field; 0x17 is 16 Mbyte.
// - Size code n means a window of two to the n+1 bytes.
// - A matching local access window overrides the boot strap routing.
// - Local access window zero wins when several windows match.
// - Window enable and target port code; 1100 steers to the fabric.
// - With the fabric boot strap, boot region accesses leave on the fabric.
// - No fabric request is issued until master enable is set.
// - CPU stays halted until the host sets the CPU enable bit.
// - Inbound target port code 1111 sends transactions to local memory.
// - Inbound write kind 0000 makes the window read only.
module serial_fabric_window_translation
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   // Boot strap
   input  wire logic        i_boot_from_fabric,
   // Configuration register port
   input  wire logic        i_cfg_wr,
   input  wire logic        i_cfg_rd,
   input  wire logic [3:0]  i_cfg_sel,
   input  wire logic [31:0] i_cfg_wdata,
   output logic [31:0]      o_cfg_rdata,
   // Local outbound request
   input  wire logic        i_loc_valid,
   input  wire logic        i_loc_write,
   input  wire logic [31:0] i_loc_addr,
   output logic             o_loc_ready,
   // Fabric request out
   output logic             o_fab_valid,
   input  wire logic        i_fab_ready,
   output logic             o_fab_write,
   output logic [3:0]       o_fab_kind,
   output logic [7:0]       o_fab_dest,
   output logic [1:0]       o_fab_ext,
   output logic [31:0]      o_fab_addr,
   output logic [1:0]       o_fab_priority,
   output logic             o_fab_ordered,
   // Local routing result
   output logic             o_route_valid,
   output logic             o_route_hit,
   output logic [3:0]       o_route_port,
   output logic [31:0]      o_route_addr,
   // Inbound fabric access
   input  wire logic        i_in_valid,
   input  wire logic        i_in_write,
   input  wire logic [1:0]  i_in_ext,
   input  wire logic [31:0] i_in_addr,
   output logic             o_in_valid,
   output logic             o_in_miss,
   output logic             o_in_refused,
   output logic             o_in_to_memory,
   output logic [31:0]      o_in_addr,
   // Agent release
   output logic             o_master_enabled,
   output logic             o_cpu_run
);

   typedef struct packed {
      logic [31:0]                                  in_trans;
      logic [31:0]                                  in_base;
      logic [31:0]                                  in_attr;
      logic [31:0]                                  out_target;
      logic [31:0]                                  out_attr;
      logic [fabric_window_pkg::NUM_LAW-1:0][31:0] law_base;
      logic [fabric_window_pkg::NUM_LAW-1:0][31:0] law_attr;
      logic                                         master_en;
      logic                                         cpu_en;
      logic                                         strap_taken;
      logic                                         boot_fabric;
      logic [31:0]                                  rdata;
      logic                                         fab_valid;
      logic                                         fab_write;
      logic [3:0]                                   fab_kind;
      logic [7:0]                                   fab_dest;
      logic [1:0]                                   fab_ext;
      logic [31:0]                                  fab_addr;
      logic [1:0]                                   fab_priority;
      logic                                         fab_ordered;
      logic                                         route_valid;
      logic                                         route_hit;
      logic [3:0]                                   route_port;
      logic [31:0]                                  route_addr;
      logic                                         in_valid;
      logic                                         in_miss;
      logic                                         in_refused;
      logic                                         in_to_memory;
      logic [31:0]                                  in_addr;
   } state_s;

   state_s      st;
   state_s      next_st;

   logic        law_hit;
   logic [3:0]  law_port;
   logic        in_hit;
   logic [31:0] in_xlat;
   logic        in_mem;
   logic        in_ref;
   logic        in_boot;
   logic        fabric_bound;
   logic        slot_free;
   logic        take;
   logic [5:0]  out_size;

   // ----------------------------------------
   // Window lookups
   // ----------------------------------------
   local_window_router u_router
   (
      .i_addr (i_loc_addr),
      .i_base (st.law_base),
      .i_attr (st.law_attr),
      .o_hit  (law_hit),
      .o_port (law_port)
   );

   inbound_translator u_inbound
   (
      .i_addr      (i_in_addr),
      .i_ext       (i_in_ext),
      .i_write     (i_in_write),
      .i_base      (st.in_base),
      .i_attr      (st.in_attr),
      .i_trans     (st.in_trans),
      .o_hit       (in_hit),
      .o_addr      (in_xlat),
      .o_to_memory (in_mem),
      .o_refused   (in_ref)
   );

   // ----------------------------------------
   // Outbound steering
   // ----------------------------------------
   always_comb
   begin
      in_boot      = (i_loc_addr & ~fabric_window_pkg::BOOT_MASK) ==
                     fabric_window_pkg::BOOT_BASE;
      // A window hit decides alone, even one that points elsewhere
      fabric_bound = law_hit ? (law_port == fabric_window_pkg::PORT_FABRIC)
                             : (st.boot_fabric && in_boot);
      slot_free    = !st.fab_valid || i_fab_ready;
      // Fabric traffic stalls at the source while mastering is off
      o_loc_ready  = fabric_bound ? (st.master_en && slot_free) : 1'b1;
      take         = i_loc_valid && o_loc_ready;
      out_size     = st.out_attr[fabric_window_pkg::SIZE_LSB +: 6];
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_st             = st;
      next_st.route_valid = 1'b0;
      next_st.in_valid    = 1'b0;

      // Strap sampled once, on the first clock after reset release
      if (!st.strap_taken)
      begin
         next_st.strap_taken = 1'b1;
         next_st.boot_fabric = i_boot_from_fabric;
      end

      // Register writes; reserved bits are never stored
      if (i_cfg_wr)
      begin
         unique case (i_cfg_sel)
            fabric_window_pkg::IDX_IN_TRANS:
               next_st.in_trans = i_cfg_wdata & fabric_window_pkg::IN_TRANS_WMASK;
            fabric_window_pkg::IDX_IN_BASE:
               next_st.in_base = i_cfg_wdata & fabric_window_pkg::IN_BASE_WMASK;
            fabric_window_pkg::IDX_IN_ATTR:
               next_st.in_attr = i_cfg_wdata & fabric_window_pkg::IN_ATTR_WMASK;
            fabric_window_pkg::IDX_OUT_TARGET:
               next_st.out_target = i_cfg_wdata & fabric_window_pkg::OUT_TARGET_WMASK;
            fabric_window_pkg::IDX_OUT_ATTR:
               next_st.out_attr = i_cfg_wdata & fabric_window_pkg::OUT_ATTR_WMASK;
            fabric_window_pkg::IDX_PORT_CTRL:
               next_st.master_en = i_cfg_wdata[fabric_window_pkg::EN_BIT];
            fabric_window_pkg::IDX_CORE_CFG:
               next_st.cpu_en = i_cfg_wdata[fabric_window_pkg::EN_BIT];
            default:
            begin
               for (int i = 0; i < fabric_window_pkg::NUM_LAW; i++)
               begin
                  if (i_cfg_sel == 4'(fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_BASE + 2 * i))
                     next_st.law_base[i] = i_cfg_wdata & fabric_window_pkg::LAW_BASE_WMASK;
                  if (i_cfg_sel == 4'(fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_ATTR + 2 * i))
                     next_st.law_attr[i] = i_cfg_wdata & fabric_window_pkg::LAW_ATTR_WMASK;
               end
            end
         endcase
      end

      // Register reads; unmapped indices return zero
      if (i_cfg_rd)
      begin
         unique case (i_cfg_sel)
            fabric_window_pkg::IDX_IN_TRANS:   next_st.rdata = st.in_trans;
            fabric_window_pkg::IDX_IN_BASE:    next_st.rdata = st.in_base;
            fabric_window_pkg::IDX_IN_ATTR:    next_st.rdata = st.in_attr;
            fabric_window_pkg::IDX_OUT_TARGET: next_st.rdata = st.out_target;
            fabric_window_pkg::IDX_OUT_ATTR:
               next_st.rdata = st.out_attr | fabric_window_pkg::OUT_ATTR_FIXED;
            fabric_window_pkg::IDX_PORT_CTRL:
               next_st.rdata = {st.master_en, 31'h0000_0000};
            fabric_window_pkg::IDX_CORE_CFG:
               next_st.rdata = {st.cpu_en, 31'h0000_0000};
            default:
            begin
               next_st.rdata = fabric_window_pkg::REG_RESET;
               for (int i = 0; i < fabric_window_pkg::NUM_LAW; i++)
               begin
                  if (i_cfg_sel == 4'(fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_BASE + 2 * i))
                     next_st.rdata = st.law_base[i];
                  if (i_cfg_sel == 4'(fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_ATTR + 2 * i))
                     next_st.rdata = st.law_attr[i];
               end
            end
         endcase
      end

      // Fabric request slot
      if (i_fab_ready)
         next_st.fab_valid = 1'b0;
      if (take && fabric_bound)
      begin
         // No other outbound window exists, so the default one takes all
         next_st.fab_valid    = 1'b1;
         next_st.fab_write    = i_loc_write;
         next_st.fab_kind     = i_loc_write
                                ? st.out_attr[fabric_window_pkg::WRK_LSB +: 4]
                                : st.out_attr[fabric_window_pkg::RDK_LSB +: 4];
         next_st.fab_dest     = st.out_target[fabric_window_pkg::DEST_LSB +: 8];
         next_st.fab_ext      = st.out_target[fabric_window_pkg::EXT_LSB +: 2];
         next_st.fab_addr     = fabric_window_pkg::translate(i_loc_addr,
                                   st.out_target[fabric_window_pkg::ADDR_LSB +: 20],
                                   out_size);
         next_st.fab_priority = st.out_attr[fabric_window_pkg::FLOW_LSB +: 2];
         next_st.fab_ordered  = st.out_attr[fabric_window_pkg::ORDER_BIT];
      end

      // Accesses that stay on chip are reported for one cycle
      if (take && !fabric_bound)
      begin
         next_st.route_valid = 1'b1;
         next_st.route_hit   = law_hit;
         next_st.route_port  = law_hit ? law_port : fabric_window_pkg::PORT_NONE;
         next_st.route_addr  = i_loc_addr;
      end

      // Inbound translation result, one cycle after the access
      if (i_in_valid)
      begin
         next_st.in_valid     = 1'b1;
         next_st.in_miss      = !in_hit;
         next_st.in_refused   = in_hit && in_ref;
         next_st.in_to_memory = in_hit && in_mem;
         next_st.in_addr      = in_hit ? in_xlat : i_in_addr;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         st <= '0;
      else
         st <= next_st;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_cfg_rdata      = st.rdata;
   assign o_fab_valid      = st.fab_valid;
   assign o_fab_write      = st.fab_write;
   assign o_fab_kind       = st.fab_kind;
   assign o_fab_dest       = st.fab_dest;
   assign o_fab_ext        = st.fab_ext;
   assign o_fab_addr       = st.fab_addr;
   assign o_fab_priority   = st.fab_priority;
   assign o_fab_ordered    = st.fab_ordered;
   assign o_route_valid    = st.route_valid;
   assign o_route_hit      = st.route_hit;
   assign o_route_port     = st.route_port;
   assign o_route_addr     = st.route_addr;
   assign o_in_valid       = st.in_valid;
   assign o_in_miss        = st.in_miss;
   assign o_in_refused     = st.in_refused;
   assign o_in_to_memory   = st.in_to_memory;
   assign o_in_addr        = st.in_addr;
   assign o_master_enabled = st.master_en;
   // Boot holdoff: core held until the host releases it
   assign o_cpu_run        = st.cpu_en;

endmodule
`default_nettype wire

/* File: testbench/fabric_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fabric_host_model
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rstn,
   // Acceptance pace
   input  wire logic i_slow,
   output logic      o_ready
);
   logic [1:0] cnt;
   // Slow host accepts one cycle in three, so held requests are exercised
   always @(negedge i_clk)
   begin
      cnt = (!i_rstn || cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      o_ready = !i_slow || cnt == 2'h2;
   end
endmodule
`default_nettype wire

/* File: testbench/serial_fabric_window_translation_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_fabric_window_translation_monitor
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   // Watched ports
   input  wire logic        i_cfg_wr,
   input  wire logic        i_cfg_rd,
   input  wire logic [3:0]  i_cfg_sel,
   input  wire logic [31:0] i_cfg_wdata,
   input  wire logic [31:0] o_cfg_rdata,
   input  wire logic        i_loc_valid,
   input  wire logic        o_loc_ready,
   input  wire logic        o_fab_valid,
   input  wire logic        i_fab_ready,
   input  wire logic [31:0] o_fab_addr,
   input  wire logic        o_route_valid,
   input  wire logic        i_in_valid,
   input  wire logic        o_in_valid,
   input  wire logic        o_master_enabled,
   input  wire logic        o_cpu_run
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   in_answer_a: assert property (i_in_valid |=> o_in_valid)
      else $error("inbound answer missing");
   in_quiet_a: assert property (!i_in_valid |=> !o_in_valid)
      else $error("inbound answer without access");
   fab_hold_a: assert property (o_fab_valid && !i_fab_ready |=> o_fab_valid && $stable(o_fab_addr))
      else $error("fabric request dropped or changed");
   master_gate_a: assert property ($rose(o_fab_valid) |-> $past(o_master_enabled && i_loc_valid))
      else $error("fabric request without master enable");
   stall_cause_a: assert property (i_loc_valid && !o_loc_ready |-> !o_master_enabled || o_fab_valid)
      else $error("local request stalled without cause");
   route_cause_a: assert property (o_route_valid |-> $past(i_loc_valid && o_loc_ready))
      else $error("route pulse without accepted request");
   attr_enable_a: assert property ($past(i_cfg_rd) && $past(i_cfg_sel) == fabric_window_pkg::IDX_OUT_ATTR |-> o_cfg_rdata[31])
      else $error("default window enable read as zero");
   master_set_a: assert property ($rose(o_master_enabled) |-> $past(i_cfg_wr && i_cfg_wdata[31] && i_cfg_sel == fabric_window_pkg::IDX_PORT_CTRL))
      else $error("master enable rose without write");
   cpu_release_a: assert property ($rose(o_cpu_run) |-> $past(i_cfg_wr && i_cfg_wdata[31] && i_cfg_sel == fabric_window_pkg::IDX_CORE_CFG))
      else $error("core released without write");
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_boot_from_fabric = 1'b1, slow = 1'b0, rd_d = 1'b0;
   logic i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_loc_valid = 1'b0, i_loc_write = 1'b0;
   logic i_in_valid = 1'b0, i_in_write = 1'b0, i_fab_ready;
   logic [3:0]  i_cfg_sel = 4'h0;
   logic [1:0]  i_in_ext = 2'b00;
   logic [31:0] i_cfg_wdata = 32'h0, i_loc_addr = 32'h0, i_in_addr = 32'h0, r = 32'hA80C_0B4F;
   logic o_loc_ready, o_fab_valid, o_fab_write, o_fab_ordered, o_route_valid, o_route_hit;
   logic o_in_valid, o_in_miss, o_in_refused, o_in_to_memory, o_master_enabled, o_cpu_run;
   logic [3:0]  o_fab_kind, o_route_port;
   logic [7:0]  o_fab_dest;
   logic [1:0]  o_fab_ext, o_fab_priority;
   logic [31:0] o_cfg_rdata, o_fab_addr, o_route_addr, o_in_addr;
   logic [49:0] fab_q[$];
   logic [34:0] in_q[$];
   logic [36:0] route_q[$];
   logic [31:0] cfg_q[$];
   int failures = 0, num_checks = 0, cyc = 0;
   always #12.5 i_ref_clk = !i_ref_clk;
   serial_fabric_window_translation serial_fabric_window_translation_i (.*);
   fabric_host_model fabric_host_model_i (.i_clk(i_ref_clk), .i_rstn(i_rstn), .i_slow(slow),
      .o_ready(i_fab_ready));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [49:0] seen, input logic [49:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Host reaches these only via its config window
   task automatic cfg(input logic rd, input logic [3:0] sel, input logic [31:0] d);
      @(negedge i_ref_clk);
      i_cfg_rd = rd;
      i_cfg_wr = !rd;
      i_cfg_sel = sel;
      i_cfg_wdata = d;
      if (rd)
         cfg_q.push_back(d);
      @(negedge i_ref_clk);
      i_cfg_rd = 1'b0;
      i_cfg_wr = 1'b0;
   endtask
   task automatic loc(input logic w, input logic [31:0] a, input logic hold);
      int n;
      @(negedge i_ref_clk);
      i_loc_valid = 1'b1;
      i_loc_write = w;
      i_loc_addr = a;
      if (hold)
      begin
         repeat (4) @(negedge i_ref_clk);
         chk({o_loc_ready, o_fab_valid, o_master_enabled}, 3'b000);
         cfg(1'b0, fabric_window_pkg::IDX_PORT_CTRL, 32'h8000_0000);
      end
      n = 0;
      do @(posedge i_ref_clk); while (o_loc_ready !== 1'b1 && n++ < 100);
      @(negedge i_ref_clk);
      i_loc_valid = 1'b0;
   endtask
   task automatic inb(input logic w, input logic [31:0] a, input logic [34:0] x);
      @(negedge i_ref_clk);
      i_in_valid = 1'b1;
      i_in_write = w;
      i_in_addr = a;
      in_q.push_back(x);
      @(negedge i_ref_clk);
      i_in_valid = 1'b0;
   endtask
   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(posedge i_ref_clk)
   begin
      cyc++;
      if (rd_d)
         chk(o_cfg_rdata, cfg_q.pop_front());
      rd_d = i_cfg_rd;
      if (o_in_valid === 1'b1)
         chk({o_in_miss, o_in_refused, o_in_to_memory, o_in_addr}, in_q.pop_front());
      if (o_fab_valid === 1'b1 && i_fab_ready === 1'b1)
         chk({o_fab_write, o_fab_kind, o_fab_dest, o_fab_ext, o_fab_addr, o_fab_priority,
              o_fab_ordered}, fab_q.pop_front());
      if (o_route_valid === 1'b1)
         chk({o_route_hit, o_route_port, o_route_addr}, route_q.pop_front());
      if (cyc == 5000)
      begin
         failures++;
         end_sim();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      repeat (8) @(negedge i_ref_clk);
      i_rstn = 1'b1;
      cfg(1'b1, fabric_window_pkg::IDX_OUT_ATTR, 32'h8000_0000);
      cfg(1'b0, fabric_window_pkg::IDX_OUT_ATTR, 32'hFFFF_FFFF);
      cfg(1'b1, fabric_window_pkg::IDX_OUT_ATTR, 32'h8E0F_F03F);
      cfg(1'b1, 4'hF, 32'h0);
      cfg(1'b0, fabric_window_pkg::IDX_IN_TRANS, 32'h000F_F800);
      cfg(1'b0, fabric_window_pkg::IDX_IN_BASE, 32'h000F_FC00);
      cfg(1'b0, fabric_window_pkg::IDX_IN_ATTR, 32'h80F4_0015);
      inb(1'b0, 32'hFFFF_FFFC, {3'h1, 32'hFFBF_FFFC});
      inb(1'b1, 32'hFFC0_0010, {3'h3, 32'hFF80_0010});
      inb(1'b0, 32'h1000_0000, {3'h4, 32'h1000_0000});
      for (int k = 0; k < 8; k++)
      begin
         r = lfsr(r);
         inb(1'b0, 32'hFFC0_0000 | (r & 32'h003F_FFFF), {3'h1, 32'hFF80_0000 | (r & 32'h003F_FFFF)});
      end
      cfg(1'b0, fabric_window_pkg::IDX_OUT_TARGET, 32'h0040_0000);
      cfg(1'b0, fabric_window_pkg::IDX_OUT_ATTR, 32'h0A04_401F);
      route_q.push_back({5'h00, 32'h1000_0000});
      loc(1'b0, 32'h1000_0000, 1'b0);
      fab_q.push_back({13'h0401, 2'b00, 32'hFFFF_FFFC, 3'b101});
      loc(1'b0, 32'hFFFF_FFFC, 1'b1);
      slow = 1'b1;
      cfg(1'b0, fabric_window_pkg::IDX_OUT_TARGET, 32'h0041_2345);
      cfg(1'b0, fabric_window_pkg::IDX_OUT_ATTR, 32'h0A04_4017);
      fab_q.push_back({13'h1401, 2'b00, 32'h12AB_CDE0, 3'b101});
      loc(1'b1, 32'hFFAB_CDE0, 1'b0);
      cfg(1'b0, fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_BASE, 32'h000F_F000);
      cfg(1'b0, fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_ATTR, 32'h8020_0017);
      cfg(1'b0, fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_BASE + 4'h2, 32'h000F_F000);
      cfg(1'b0, fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_ATTR + 4'h2, 32'h80C0_0017);
      route_q.push_back({5'h12, 32'hFFF0_0000});
      loc(1'b0, 32'hFFF0_0000, 1'b0);
      cfg(1'b0, fabric_window_pkg::IDX_LOCAL_ACCESS_WINDOW_ZERO_BASE + 4'h2, 32'h0004_0000);
      fab_q.push_back({13'h0401, 2'b00, 32'h1200_0010, 3'b101});
      loc(1'b0, 32'h4000_0010, 1'b0);
      cfg(1'b0, fabric_window_pkg::IDX_CORE_CFG, 32'h8000_0000);
      chk(o_cpu_run, 1'b1);
      repeat (20) @(negedge i_ref_clk);
      chk(fab_q.size() + in_q.size() + route_q.size() + cfg_q.size(), 0);
      end_sim();
   end
endmodule
bind serial_fabric_window_translation serial_fabric_window_translation_monitor mon_i (.i_ref_clk,
   .i_rstn, .i_cfg_wr, .i_cfg_rd, .i_cfg_sel, .i_cfg_wdata, .o_cfg_rdata, .i_loc_valid,
   .o_loc_ready, .o_fab_valid, .i_fab_ready, .o_fab_addr, .o_route_valid, .i_in_valid,
   .o_in_valid, .o_master_enabled, .o_cpu_run);
`default_nettype wire
